// file: design/ghoc_pkg.sv
// Constants shared by the handshake option and address status block.
// Assumes a 125 MHz system clock and byte-wide host port offsets.
package ghoc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and settling times
	localparam int CLK_PERIOD_NS = 8;
	localparam int T1_FAST_NS = 500;
	localparam int T1_SLOW_NS = 2000;
	// Least times, rounded up to whole cycles
	localparam int T1_FAST_CYC = (T1_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T1_SLOW_CYC = (T1_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T1_CW = 8;

	////////////////////////////////////////////////////////////////////////
	// Host port offsets
	localparam logic [2:0] OFS_AUX_MODE = 3'h5;
	localparam logic [2:0] OFS_PASSTHRU_CMD = 3'h5;
	localparam logic [2:0] OFS_ADDRESS = 3'h6;

	////////////////////////////////////////////////////////////////////////
	// Auxiliary mode register layout and control codes
	localparam int AUX_CODE_LSB = 5;
	localparam logic [2:0] CODE_AUX_CMD = 3'b000;
	localparam logic [2:0] CODE_HSO_REG = 3'b101;
	localparam logic [2:0] CODE_DAC_CFG = 3'b110;
	localparam logic [4:0] AUX_CMD_FINISH = 5'h03;
	localparam logic [4:0] AUX_CMD_VALID = 5'h0f;

	////////////////////////////////////////////////////////////////////////
	// Handshake option register fields
	localparam int HSO_ISS = 4;
	localparam int HSO_INV = 3;
	localparam int HSO_TRI = 2;
	localparam int HSO_SERIAL_POLL_END_ENABLE = 1;
	localparam int HSO_PASSTHRU = 0;
	localparam logic [4:0] HSO_RESET = 5'h00;

	////////////////////////////////////////////////////////////////////////
	// DAC holdoff configuration fields
	localparam int DHC_TRIG = 1;
	localparam int DHC_CLEAR = 0;
	localparam logic [1:0] DHC_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Address register fields and address formation
	localparam int ADR_SEL = 7;
	localparam int ADR_TALK_DIS = 6;
	localparam int ADR_LISTEN_DIS = 5;
	localparam logic [6:0] ADR_RESET = 7'h00;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// file: design/ghoc_holdoff.sv
// Bank of handshake holdoff latches with a registered summary.
// Assumes set and release are one-cycle pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
module ghoc_holdoff
	import ghoc_pkg::*;
#(
	parameter int N = 3
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [N-1:0] hold_set,
	input wire logic [N-1:0] hold_release,
	output logic [N-1:0] hold_q,
	output logic hold_any_q
);

	typedef struct packed {
		logic [N-1:0] hold;
		logic any;
	} ghoc_hold_t;

	ghoc_hold_t s_q;
	ghoc_hold_t s_d;

	////////////////////////////////////////////////////////////////////////
	// Set wins over release in the same cycle
	always_comb
	begin
		s_d = s_q;
		s_d.hold = hold_set | (s_q.hold & ~hold_release);
		s_d.any = |s_d.hold;
	end

	// State register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign hold_q = s_q.hold;
	assign hold_any_q = s_q.any;

endmodule
`default_nettype wire

// file: design/ghoc_settle_timer.sv
// Source handshake settling timer with two selectable lengths.
// Assumes lengths of at least two cycles and a one-cycle start pulse.
`timescale 1ns/1ps
`default_nettype none
module ghoc_settle_timer
	import ghoc_pkg::*;
#(
	parameter int CW = T1_CW,
	parameter logic [CW-1:0] FAST_CYC = CW'(T1_FAST_CYC),
	parameter logic [CW-1:0] SLOW_CYC = CW'(T1_SLOW_CYC)
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic start,
	input wire logic fast,
	output logic done_q
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COUNT = 2'b01,
		ST_DONE = 2'b11
	} ghoc_tmr_st_t;

	typedef struct packed {
		ghoc_tmr_st_t st;
		logic [CW-1:0] cnt;
		logic done;
	} ghoc_tmr_t;

	ghoc_tmr_t s_q;
	ghoc_tmr_t s_d;

	////////////////////////////////////////////////////////////////////////
	// Load on start, count down, flag done until the next start
	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			ST_IDLE, ST_DONE:
			begin
				if (start)
				begin
					s_d.st = ST_COUNT;
					s_d.done = 1'b0;
					s_d.cnt = (fast ? FAST_CYC : SLOW_CYC) - CW'(1);
				end
			end
			ST_COUNT:
			begin
				s_d.cnt = s_q.cnt - CW'(1);
				if (start)
					s_d.cnt = (fast ? FAST_CYC : SLOW_CYC) - CW'(1);
				else if (s_q.cnt == CW'(1))
				begin
					s_d.st = ST_DONE;
					s_d.done = 1'b1;
				end
			end
			default:
			begin
				s_d.st = ST_IDLE;
				s_d.done = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			s_q <= '{st: ST_IDLE, cnt: '0, done: 1'b0};
		else
			s_q <= s_d;
	end

	assign done_q = s_q.done;

endmodule
`default_nettype wire

// file: design/ghoc_top.sv
// Handshake options, DAC holdoff and primary address status of the
// bus interface chip. Assumes host strobes and chip events share mclk.
`timescale 1ns/1ps
`default_nettype none
module ghoc_top
	import ghoc_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [2:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic cmd_strobe,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_undefined,
	input wire logic flag_clear,
	input wire logic dtas_enter,
	input wire logic dcas_enter,
	input wire logic spas,
	input wire logic src_eoi,
	input wire logic src_eoi_oe,
	input wire logic ppoll_active,
	input wire logic t1_start,
	input wire logic first_byte,
	output logic t1_done,
	output logic dio_open_collector,
	output logic eoi_out,
	output logic eoi_oe,
	output logic undefined_cmd_flag,
	output logic dac_hold,
	output logic talk_addr_hit,
	output logic listen_addr_hit,
	output logic [6:0] secondary_addr,
	output logic iss_select,
	output logic int_invert
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [4:0] hso;
		logic [1:0] dhc;
		logic [6:0] pri_addr;
		logic [6:0] sec_addr;
		logic [7:0] pt_cmd;
		logic pt_flag;
		logic [7:0] rdata;
		logic finish_p;
		logic valid_p;
		logic eoi_out;
		logic eoi_oe;
		logic oc_mode;
		logic talk_hit;
		logic listen_hit;
	} ghoc_state_t;

	ghoc_state_t s_q;
	ghoc_state_t s_d;

	localparam int AST_FAST_M1 = T1_FAST_CYC - 1;
	localparam int AST_SLOW_M1 = T1_SLOW_CYC - 1;

	logic [2:0] aux_control_code;
	logic [4:0] aux_command_bits;
	logic wr_aux;
	logic wr_adr;
	logic pt_event;
	logic [2:0] hold_set;
	logic [2:0] hold_release;
	logic [2:0] hold_vec;
	logic hold_any;
	logic t1_fast;

	// Bus address formed from a base and the five address bits
	function automatic logic [7:0] addr_form(input logic [7:0] base, input logic [4:0] ad);
		addr_form = base + {3'b000, ad};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Host write decode
	assign wr_aux = host_wr && (host_addr == OFS_AUX_MODE);
	assign wr_adr = host_wr && (host_addr == OFS_ADDRESS);
	assign aux_control_code = host_wdata[7:AUX_CODE_LSB];
	assign aux_command_bits = host_wdata[AUX_CODE_LSB-1:0];
	assign pt_event = cmd_strobe && cmd_undefined && s_q.hso[HSO_PASSTHRU];

	// Holdoff sources: pass-through, trigger, clear
	assign hold_set[0] = pt_event;
	assign hold_set[1] = dtas_enter && s_q.dhc[DHC_TRIG];
	assign hold_set[2] = dcas_enter && s_q.dhc[DHC_CLEAR];
	assign hold_release[0] = s_q.valid_p;
	assign hold_release[2:1] = {2{s_q.finish_p}};

	// Fast settling only past the first byte
	assign t1_fast = s_q.hso[HSO_TRI] && !first_byte;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.finish_p = 1'b0;
		s_d.valid_p = 1'b0;
		if (wr_aux)
		begin
			case (aux_control_code)
				CODE_HSO_REG: s_d.hso = aux_command_bits;
				CODE_DAC_CFG: s_d.dhc = aux_command_bits[1:0];
				CODE_AUX_CMD:
				begin
					s_d.finish_p = (aux_command_bits == AUX_CMD_FINISH);
					s_d.valid_p = (aux_command_bits == AUX_CMD_VALID);
				end
				default: s_d.finish_p = 1'b0;
			endcase
		end
		// Address register select
		if (wr_adr)
		begin
			if (host_wdata[ADR_SEL])
				s_d.sec_addr = host_wdata[6:0];
			else
				s_d.pri_addr = host_wdata[6:0];
		end
		// Pass-through flag, set wins over clear
		if (flag_clear)
			s_d.pt_flag = 1'b0;
		if (pt_event)
		begin
			s_d.pt_flag = 1'b1;
			s_d.pt_cmd = cmd_byte;
		end
		// Host read data
		if (host_rd)
		begin
			case (host_addr)
				OFS_ADDRESS: s_d.rdata = {1'b0, s_q.pri_addr};
				OFS_PASSTHRU_CMD: s_d.rdata = s_q.pt_cmd;
				default: s_d.rdata = BYTE_RESET;
			endcase
		end
		// EOI drive and driver mode
		s_d.eoi_out = spas ? s_q.hso[HSO_SERIAL_POLL_END_ENABLE] : src_eoi;
		s_d.eoi_oe = spas || src_eoi_oe;
		s_d.oc_mode = ppoll_active;
		// Own address recognition
		s_d.talk_hit = cmd_strobe && !s_q.pri_addr[ADR_TALK_DIS]
			&& (cmd_byte == addr_form(TALK_BASE, s_q.pri_addr[4:0]));
		s_d.listen_hit = cmd_strobe && !s_q.pri_addr[ADR_LISTEN_DIS]
			&& (cmd_byte == addr_form(LISTEN_BASE, s_q.pri_addr[4:0]));
	end

	// State register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_q <= '0;
			s_q.hso <= HSO_RESET;
			s_q.dhc <= DHC_RESET;
			s_q.pri_addr <= ADR_RESET;
			s_q.sec_addr <= ADR_RESET;
			s_q.pt_cmd <= BYTE_RESET;
			s_q.rdata <= BYTE_RESET;
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Submodules
	ghoc_holdoff #(
		.N(3)
	) u_holdoff (
		.mclk(mclk),
		.nrst(nrst),
		.hold_set(hold_set),
		.hold_release(hold_release),
		.hold_q(hold_vec),
		.hold_any_q(hold_any)
	);

	ghoc_settle_timer u_settle (
		.mclk(mclk),
		.nrst(nrst),
		.start(t1_start),
		.fast(t1_fast),
		.done_q(t1_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign host_rdata = s_q.rdata;
	assign dio_open_collector = s_q.oc_mode;
	assign eoi_out = s_q.eoi_out;
	assign eoi_oe = s_q.eoi_oe;
	assign undefined_cmd_flag = s_q.pt_flag;
	assign dac_hold = hold_any;
	assign talk_addr_hit = s_q.talk_hit;
	assign listen_addr_hit = s_q.listen_hit;
	assign secondary_addr = s_q.sec_addr;
	assign iss_select = s_q.hso[HSO_ISS];
	assign int_invert = s_q.hso[HSO_INV];

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking ast_clk @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence s_fast_start;
		t1_start && t1_fast;
	endsequence

	sequence s_slow_start;
		t1_start && !t1_fast;
	endsequence

	sequence s_finish_wr;
		wr_aux && (aux_control_code == CODE_AUX_CMD) && (aux_command_bits == AUX_CMD_FINISH);
	endsequence

	sequence s_valid_wr;
		wr_aux && (aux_control_code == CODE_AUX_CMD) && (aux_command_bits == AUX_CMD_VALID);
	endsequence

	AST_T1_FAST: assert property (s_fast_start ##1 (!t1_start)[*2] |->
		##(AST_FAST_M1 - 2) !t1_done ##1 t1_done)
		else $error("fast settle length wrong");

	AST_T1_SLOW: assert property (s_slow_start ##1 (!t1_start)[*2] |->
		##(AST_SLOW_M1 - 2) !t1_done ##1 t1_done)
		else $error("slow settle length wrong");

	AST_OC_MODE: assert property (ppoll_active |=> dio_open_collector)
		else $error("drivers not open-collector in parallel poll");

	AST_SP_EOI: assert property (spas && !$past(wr_aux) |=> eoi_oe && (eoi_out == $past(s_q.hso[HSO_SERIAL_POLL_END_ENABLE])))
		else $error("EOI wrong in serial poll");

	AST_PT_FLAG: assert property (cmd_strobe && cmd_undefined && s_q.hso[HSO_PASSTHRU] |=>
		undefined_cmd_flag && (s_q.pt_cmd == $past(cmd_byte)))
		else $error("pass-through flag or byte not captured");

	AST_PT_OFF: assert property (!s_q.hso[HSO_PASSTHRU] && !undefined_cmd_flag |=> !undefined_cmd_flag)
		else $error("pass-through flag set while disabled");

	AST_PT_HOLD: assert property (pt_event |=> dac_hold)
		else $error("pass-through did not hold DAC");

	AST_DAC_CFG: assert property (wr_aux && aux_control_code == CODE_DAC_CFG |=>
		s_q.dhc == $past(host_wdata[1:0]))
		else $error("holdoff config not stored");

	AST_TRIG_HOLD: assert property (dtas_enter && s_q.dhc[DHC_TRIG] |=> dac_hold)
		else $error("trigger holdoff missing");

	AST_CLR_HOLD: assert property (dcas_enter && s_q.dhc[DHC_CLEAR] |=> dac_hold)
		else $error("clear holdoff missing");

	AST_FIN_REL: assert property (s_finish_wr ##1 !dtas_enter && !dcas_enter |=> !hold_vec[1] && !hold_vec[2])
		else $error("finish did not release holdoff");

	AST_VAL_REL: assert property (s_valid_wr ##1 !pt_event |=> !hold_vec[0])
		else $error("valid did not release pass-through hold");

	AST_ADDR_RD: assert property (host_rd && host_addr == OFS_ADDRESS |=>
		host_rdata == {1'b0, $past(s_q.pri_addr)})
		else $error("address status read wrong");

	AST_TALK_HIT: assert property (cmd_strobe && !s_q.pri_addr[ADR_TALK_DIS]
		&& cmd_byte == addr_form(TALK_BASE, s_q.pri_addr[4:0]) |=> talk_addr_hit)
		else $error("talk address not recognised");

	AST_LISTEN_DIS: assert property (s_q.pri_addr[ADR_LISTEN_DIS] |=> !listen_addr_hit)
		else $error("disabled listener responded");

	AST_HSO_WR: assert property (wr_aux && aux_control_code == CODE_HSO_REG |=>
		s_q.hso == $past(aux_command_bits))
		else $error("handshake options not stored");

	AST_ADR_WR: assert property (wr_adr && host_wdata[ADR_SEL] |=>
		secondary_addr == $past(host_wdata[6:0]))
		else $error("secondary address not loaded");

	AST_ADR_PRI: assert property (wr_adr && !host_wdata[ADR_SEL] |=>
		s_q.pri_addr == $past(host_wdata[6:0]))
		else $error("primary address not loaded");

	// Own address recognition, enabled and disabled
	AST_TALK_DIS: assert property (s_q.pri_addr[ADR_TALK_DIS] |=> !talk_addr_hit)
		else $error("disabled talker responded");

	AST_LISTEN_HIT: assert property (cmd_strobe && !s_q.pri_addr[ADR_LISTEN_DIS]
		&& cmd_byte == addr_form(LISTEN_BASE, s_q.pri_addr[4:0]) |=> listen_addr_hit)
		else $error("listen address not recognised");

	// Captured command byte reaches the host; drivers not open-collector outside parallel poll
	AST_PT_RD: assert property (host_rd && host_addr == OFS_PASSTHRU_CMD |=>
		host_rdata == $past(s_q.pt_cmd))
		else $error("pass-through byte read wrong");

	AST_OC_OFF: assert property (!ppoll_active |=> !dio_open_collector)
		else $error("drivers open-collector outside parallel poll");

	// Holds persist until their own release pulse
	AST_TRIG_KEEP: assert property (hold_vec[1] && !s_q.finish_p |=> hold_vec[1])
		else $error("trigger holdoff dropped early");

	AST_CLR_KEEP: assert property (hold_vec[2] && !s_q.finish_p |=> hold_vec[2])
		else $error("clear holdoff dropped early");

	AST_PT_KEEP: assert property (hold_vec[0] && !s_q.valid_p |=> hold_vec[0])
		else $error("pass-through holdoff dropped early");

	// Release pulses come only from aux command writes
	AST_NO_PULSE: assert property (!wr_aux |=> !s_q.finish_p && !s_q.valid_p)
		else $error("release pulse without a command write");

	AST_FIN_PULSE: assert property (s_finish_wr |=>
		s_q.finish_p && !s_q.valid_p)
		else $error("finish command not decoded");

endmodule
`default_nettype wire

// file: bench/ghoc_bus_model.sv
// Far-side bus model: an instrument that sends command bytes.
// Assumes one caller at a time, driving at falling mclk edges.
`timescale 1ns/1ps
`default_nettype none
module ghoc_bus_model
(
	input wire logic mclk,
	output logic cmd_strobe,
	output logic [7:0] cmd_byte,
	output logic cmd_undefined
);
	// Idle bus at time zero
	initial
	begin
		cmd_strobe = 1'b0;
		cmd_byte = 8'h00;
		cmd_undefined = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// One byte for one cycle; released lines then show the inverse
	task automatic send(input logic [7:0] b, input logic u);
		@(negedge mclk);
		cmd_strobe = 1'b1;
		cmd_byte = b;
		cmd_undefined = u;
		@(negedge mclk);
		cmd_strobe = 1'b0;
		cmd_byte = ~b;
		cmd_undefined = ~u;
	endtask
endmodule
`default_nettype wire

// file: bench/ghoc_top_tb.sv
// Self-checking bench of the option, holdoff and address block.
// Assumes the bus model drives commands; host side driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module ghoc_top_tb
	import ghoc_pkg::*;
;
	logic mclk, nrst, host_wr, host_rd, cmd_strobe, cmd_undefined, flag_clear;
	logic dtas_enter, dcas_enter, spas, src_eoi, src_eoi_oe, ppoll_active, t1_start, first_byte;
	logic t1_done, dio_open_collector, eoi_out, eoi_oe, undefined_cmd_flag, dac_hold;
	logic talk_addr_hit, listen_addr_hit, iss_select, int_invert;
	logic [2:0] host_addr;
	logic [7:0] host_wdata, host_rdata, cmd_byte, r;
	logic [6:0] secondary_addr;
	int fails = 0;
	int check_count = 0;

	ghoc_bus_model u_bus (.mclk(mclk), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte),
		.cmd_undefined(cmd_undefined));

	ghoc_top u_dut (.mclk(mclk), .nrst(nrst), .host_addr(host_addr), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte), .cmd_undefined(cmd_undefined),
		.flag_clear(flag_clear), .dtas_enter(dtas_enter), .dcas_enter(dcas_enter), .spas(spas),
		.src_eoi(src_eoi), .src_eoi_oe(src_eoi_oe), .ppoll_active(ppoll_active),
		.t1_start(t1_start), .first_byte(first_byte), .t1_done(t1_done),
		.dio_open_collector(dio_open_collector), .eoi_out(eoi_out), .eoi_oe(eoi_oe),
		.undefined_cmd_flag(undefined_cmd_flag), .dac_hold(dac_hold),
		.talk_addr_hit(talk_addr_hit), .listen_addr_hit(listen_addr_hit),
		.secondary_addr(secondary_addr), .iss_select(iss_select), .int_invert(int_invert));

	// 125 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////
	// Bus helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge mclk);
		host_wr = 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] q);
		@(negedge mclk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge mclk);
		host_rd = 1'b0;
		q = host_rdata;
	endtask

	// One-cycle event: 0 trigger, 1 clear, 2 flag clear, 3 settle start
	task automatic ev(input int k);
		@(negedge mclk);
		case (k)
			0: dtas_enter = 1'b1;
			1: dcas_enter = 1'b1;
			2: flag_clear = 1'b1;
			default: t1_start = 1'b1;
		endcase
		@(negedge mclk);
		{dtas_enter, dcas_enter, flag_clear, t1_start} = 4'h0;
	endtask

	task automatic t1(input logic fb, input int n);
		first_byte = fb;
		ev(3);
		cyc(n - 2);
		`CHK(t1_done, 1'b0)
		cyc(1);
		`CHK(t1_done, 1'b1)
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		rd(3'h6, r);
		`CHK(r, 8'h00)
		wr(3'h6, 8'h05);
		wr(3'h6, 8'h9a);
		cyc(1);
		`CHK(secondary_addr, 7'h1a)
		rd(3'h6, r);
		`CHK(r[6:0], 7'h05)
		rd(3'h3, r);
		`CHK(r, 8'h00)
	endtask

	task automatic t_addr();
		u_bus.send(8'h45, 1'b0);
		`CHK({talk_addr_hit, listen_addr_hit}, 2'b10)
		u_bus.send(8'h25, 1'b0);
		`CHK({talk_addr_hit, listen_addr_hit}, 2'b01)
		u_bus.send(8'h46, 1'b0);
		`CHK(talk_addr_hit, 1'b0)
		wr(3'h6, 8'h45);
		u_bus.send(8'h45, 1'b0);
		`CHK(talk_addr_hit, 1'b0)
		wr(3'h6, 8'h25);
		u_bus.send(8'h25, 1'b0);
		`CHK(listen_addr_hit, 1'b0)
		u_bus.send(8'h45, 1'b0);
		`CHK(talk_addr_hit, 1'b1)
	endtask

	task automatic t_cpt();
		u_bus.send(8'h9c, 1'b1);
		cyc(2);
		`CHK({undefined_cmd_flag, dac_hold}, 2'b00)
		wr(3'h5, 8'ha1);
		u_bus.send(8'h9c, 1'b1);
		`CHK(undefined_cmd_flag, 1'b1)
		cyc(2);
		`CHK(dac_hold, 1'b1)
		rd(3'h5, r);
		`CHK(r, 8'h9c)
		wr(3'h5, {CODE_AUX_CMD, AUX_CMD_FINISH});
		cyc(2);
		`CHK(dac_hold, 1'b1)
		wr(3'h5, {CODE_AUX_CMD, AUX_CMD_VALID});
		cyc(2);
		`CHK(dac_hold, 1'b0)
		ev(2);
		`CHK(undefined_cmd_flag, 1'b0)
	endtask

	task automatic t_dac();
		wr(3'h5, 8'hc2);
		ev(1);
		cyc(2);
		`CHK(dac_hold, 1'b0)
		ev(0);
		cyc(2);
		`CHK(dac_hold, 1'b1)
		wr(3'h5, {CODE_AUX_CMD, AUX_CMD_VALID});
		cyc(2);
		`CHK(dac_hold, 1'b1)
		wr(3'h5, {CODE_AUX_CMD, AUX_CMD_FINISH});
		cyc(2);
		`CHK(dac_hold, 1'b0)
		wr(3'h5, 8'hc1);
		ev(0);
		cyc(2);
		`CHK(dac_hold, 1'b0)
		ev(1);
		cyc(2);
		`CHK(dac_hold, 1'b1)
		wr(3'h5, {CODE_AUX_CMD, AUX_CMD_FINISH});
		cyc(2);
		`CHK(dac_hold, 1'b0)
	endtask

	task automatic t_eoi();
		wr(3'h5, 8'hba);
		spas = 1'b1;
		cyc(2);
		`CHK({eoi_oe, eoi_out, iss_select, int_invert}, 4'hf)
		wr(3'h5, 8'ha0);
		cyc(2);
		`CHK({eoi_oe, eoi_out}, 2'b10)
		spas = 1'b0;
		src_eoi = 1'b1;
		src_eoi_oe = 1'b1;
		ppoll_active = 1'b1;
		cyc(2);
		`CHK({eoi_out, dio_open_collector}, 2'b11)
		ppoll_active = 1'b0;
		cyc(2);
		`CHK(dio_open_collector, 1'b0)
	endtask

	// Mid-run reset drops holds, addresses and EOI drive
	task automatic t_reset();
		wr(3'h6, 8'h85);
		ev(1);
		`CHK(dac_hold, 1'b1)
		@(negedge mclk);
		nrst = 1'b0;
		cyc(2);
		`CHK({dac_hold, eoi_out, eoi_oe, secondary_addr}, 10'h000)
		nrst = 1'b1;
		rd(3'h6, r);
		`CHK(r, 8'h00)
	endtask

	////////////////////////////////////////////////////////////////
	// Verdict and run control
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#50000;
		fails++;
		final_report();
	end

	// Reset, then each scenario in turn
	initial
	begin
		nrst = 1'b0;
		{host_wr, host_rd, flag_clear, dtas_enter, dcas_enter, spas} = 6'h00;
		{src_eoi, src_eoi_oe, ppoll_active, t1_start, first_byte} = 5'h00;
		host_addr = 3'h0;
		host_wdata = 8'h00;
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		nrst = 1'b1;
		t_regs();
		t_addr();
		t_cpt();
		t_dac();
		t_eoi();
		t_reset();
		wr(3'h5, 8'ha4);
		t1(1'b0, T1_FAST_CYC);
		t1(1'b1, T1_SLOW_CYC);
		wr(3'h5, 8'ha0);
		t1(1'b0, T1_SLOW_CYC);
		final_report();
	end
endmodule
`default_nettype wire
